// ===== design/timebase_consts.svh
`ifndef TIMEBASE_CONSTS_SVH
`define TIMEBASE_CONSTS_SVH

// Register byte offsets on the APB bus.
`define CLK_CTRL_OFF 8'h00
`define T0_CTRL_OFF 8'h04
`define T0_CNT_OFF 8'h08
`define T0_RLD_OFF 8'h0C
`define T0_PWM_OFF 8'h10
`define T1_CTRL_OFF 8'h14
`define T1_CNT_OFF 8'h18
`define T1_RLD_OFF 8'h1C
`define T1_PWM_OFF 8'h20
`define T2_CTRL_OFF 8'h24
`define T2_CNT_OFF 8'h28
`define T2_RLD_OFF 8'h2C
`define CMP0_OFF 8'h30
`define CC_EN_OFF 8'h40
`define WD_CTRL_OFF 8'h44
`define WD_CNT_OFF 8'h48
`define WD_LIM_OFF 8'h4C

// Field positions.
`define TPS_LSB 0
`define TPS_MSB 3
`define TC_RUN_BIT 0
`define TC_CMODE_BIT 1
`define TC_MODE_BIT 2
`define TC_LEN_LSB 4
`define TC_LEN_MSB 6
`define TC_PWM_BIT 7
`define T2_RUN_BIT 0
`define T2_CMODE_BIT 1
`define T2_CAP_BIT 2
`define T2_EXEN_BIT 3
`define WD_EN_BIT 0
`define WD_CLR_BIT 1

// Prescale codes and counts.
`define TPS_T2_DIV12_CODE 4'hD
`define T2_DIV12_LAST 4'hB

// Reset values.
`define TPS_RST 4'h0
`define WD_LIM_RST 16'hFFFF

`endif

// ===== design/timebase_pkg.sv
package timebase_pkg;

	typedef struct packed {
		logic run;
		logic cnt_mode;
		logic reload_mode;
		logic [2:0] len;
		logic pwm_en;
		logic [15:0] cnt;
		logic [15:0] rld;
		logic [7:0] duty;
	} tmr01_type;

	typedef struct packed {
		logic timer0_count_input;
		logic timer1_count_input;
		logic timer2_count_input;
		logic timer2_capture_reload_input;
	} pin_in_type;

	typedef struct packed {
		logic [1:0] tmr_pwm;
		logic [3:0] cc_pwm;
		logic t1_baud;
		logic t2_baud;
		logic wd_timeout;
	} tmr_out_type;

	typedef struct packed {
		logic [3:0] timer_prescale_select;
		tmr01_type [1:0] t;
		logic t2_run;
		logic t2_cmode;
		logic t2_cap;
		logic t2_exen;
		logic [15:0] t2_cnt;
		logic [15:0] t2_rld;
		logic [3:0][15:0] cmp;
		logic [3:0] cc_en;
		logic wd_en;
		logic [15:0] wd_cnt;
		logic [15:0] wd_lim;
		logic [3:0] pre;
		logic [3:0] pre2;
		logic [3:0] smp1;
		logic [3:0] smp2;
		tmr_out_type out;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} state_type;

endpackage

// ===== design/timer_timebase_prescaler.sv
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "timebase_consts.svh"

module timer_timebase_prescaler
	import timebase_pkg::*;
#(
	parameter int CHANNELS = 4
) (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Timer pins.
	input wire pin_in_type pins,
	output tmr_out_type tmr_out
);

	if (CHANNELS < 1 || CHANNELS > 4) begin : g_chk
		$error("CHANNELS must be 1 to 4");
	end

	state_type state_ff;
	state_type nxt_state;

	logic [7:0] addr;
	logic setup_ph;
	logic wr_en;
	logic hit;
	logic [31:0] rd;
	logic tick_main;
	logic tick_t2;
	logic [3:0] t2_last;
	logic [3:0] fall;
	logic [1:0] inc01;
	logic [15:0] mask;
	logic t2_inc;
	logic wd_inc;

	assign addr = {paddr[7:2], 2'b00};
	assign setup_ph = psel & ~penable;
	assign wr_en = psel & penable & state_ff.pready & pwrite;

	always_comb begin
		hit = 1'b1;
		rd = 32'h0000_0000;
		case (addr)
			`CLK_CTRL_OFF: rd[`TPS_MSB:`TPS_LSB] = state_ff.timer_prescale_select;
			`T0_CTRL_OFF, `T1_CTRL_OFF: begin
				rd[`TC_RUN_BIT] = state_ff.t[addr[4]].run;
				rd[`TC_CMODE_BIT] = state_ff.t[addr[4]].cnt_mode;
				rd[`TC_MODE_BIT] = state_ff.t[addr[4]].reload_mode;
				rd[`TC_LEN_MSB:`TC_LEN_LSB] = state_ff.t[addr[4]].len;
				rd[`TC_PWM_BIT] = state_ff.t[addr[4]].pwm_en;
			end
			`T0_CNT_OFF, `T1_CNT_OFF: rd[15:0] = state_ff.t[addr[4]].cnt;
			`T0_RLD_OFF, `T1_RLD_OFF: rd[15:0] = state_ff.t[addr[4]].rld;
			`T0_PWM_OFF: rd[7:0] = state_ff.t[0].duty;
			`T1_PWM_OFF: rd[7:0] = state_ff.t[1].duty;
			`T2_CTRL_OFF: begin
				rd[`T2_RUN_BIT] = state_ff.t2_run;
				rd[`T2_CMODE_BIT] = state_ff.t2_cmode;
				rd[`T2_CAP_BIT] = state_ff.t2_cap;
				rd[`T2_EXEN_BIT] = state_ff.t2_exen;
			end
			`T2_CNT_OFF: rd[15:0] = state_ff.t2_cnt;
			`T2_RLD_OFF: rd[15:0] = state_ff.t2_rld;
			`CC_EN_OFF: rd[3:0] = state_ff.cc_en;
			`WD_CTRL_OFF: rd[`WD_EN_BIT] = state_ff.wd_en;
			`WD_CNT_OFF: rd[15:0] = state_ff.wd_cnt;
			`WD_LIM_OFF: rd[15:0] = state_ff.wd_lim;
			default: begin
				hit = 1'b0;
				for (int c = 0; c < CHANNELS; c++) begin
					if (addr == `CMP0_OFF + 8'(4 * c)) begin
						hit = 1'b1;
						rd[15:0] = state_ff.cmp[c];
					end
				end
			end
		endcase
	end

	// Timer 2 prescale end count.
	always_comb begin
		if (state_ff.timer_prescale_select == `TPS_T2_DIV12_CODE) begin
			t2_last = `T2_DIV12_LAST;
		end else begin
			t2_last = state_ff.timer_prescale_select;
		end
	end

	assign tick_main = (state_ff.pre == state_ff.timer_prescale_select);
	assign tick_t2 = (state_ff.pre2 == t2_last);
	assign fall = state_ff.smp2 & ~state_ff.smp1;

	always_comb begin
		nxt_state = state_ff;
		mask = 16'hFFFF;
		inc01 = 2'b00;

		nxt_state.smp1 = pins;
		nxt_state.smp2 = state_ff.smp1;

		if (tick_main) begin
			nxt_state.pre = 4'h0;
		end else begin
			nxt_state.pre = state_ff.pre + 4'h1;
		end
		if (tick_t2 || state_ff.pre2 > t2_last) begin
			nxt_state.pre2 = 4'h0;
		end else begin
			nxt_state.pre2 = state_ff.pre2 + 4'h1;
		end

		// Timers 0 and 1.
		nxt_state.out.t1_baud = 1'b0;
		for (int i = 0; i < 2; i++) begin
			// count per prescale tick, or per falling pin edge in counter mode
			// Timer 0 input is the top bit of the pin struct, timer 1 the next.
			inc01[i] = state_ff.t[i].run & (state_ff.t[i].cnt_mode ? fall[3 - i] : tick_main);
			mask = 16'hFFFF >> (3'd7 - state_ff.t[i].len);
			if (inc01[i]) begin
				if (state_ff.t[i].reload_mode) begin
					if (state_ff.t[i].cnt == 16'hFFFF) begin
						nxt_state.t[i].cnt = state_ff.t[i].rld;
					end else begin
						nxt_state.t[i].cnt = state_ff.t[i].cnt + 16'h0001;
					end
				end else if ((state_ff.t[i].cnt & mask) == mask) begin
					nxt_state.t[i].cnt = 16'h0000;
				end else begin
					nxt_state.t[i].cnt = (state_ff.t[i].cnt + 16'h0001) & mask;
				end
			end
			nxt_state.out.tmr_pwm[i] = state_ff.t[i].pwm_en
				& (state_ff.t[i].cnt[7:0] < state_ff.t[i].duty);
		end
		if (inc01[1] && state_ff.t[1].cnt == (state_ff.t[1].reload_mode ? 16'hFFFF : mask)) begin
			nxt_state.out.t1_baud = 1'b1;
		end

		// Timer 2.
		nxt_state.out.t2_baud = 1'b0;
		t2_inc = state_ff.t2_run & (state_ff.t2_cmode ? fall[1] : tick_t2);
		if (t2_inc) begin
			if (state_ff.t2_cnt == 16'hFFFF) begin
				nxt_state.t2_cnt = state_ff.t2_rld;
				nxt_state.out.t2_baud = 1'b1;
			end else begin
				nxt_state.t2_cnt = state_ff.t2_cnt + 16'h0001;
			end
		end
		if (state_ff.t2_exen && fall[0]) begin
			if (state_ff.t2_cap) begin
				nxt_state.t2_rld = state_ff.t2_cnt;
			end else begin
				nxt_state.t2_cnt = state_ff.t2_rld;
			end
		end

		nxt_state.out.cc_pwm = 4'h0;
		for (int c = 0; c < CHANNELS; c++) begin
			nxt_state.out.cc_pwm[c] = state_ff.cc_en[c] & (state_ff.t2_cnt < state_ff.cmp[c]);
		end

		nxt_state.out.wd_timeout = 1'b0;
		wd_inc = state_ff.wd_en & tick_main;
		if (wd_inc) begin
			if (state_ff.wd_cnt == state_ff.wd_lim) begin
				nxt_state.wd_cnt = 16'h0000;
				nxt_state.out.wd_timeout = 1'b1;
			end else begin
				nxt_state.wd_cnt = state_ff.wd_cnt + 16'h0001;
			end
		end

		// Software writes take priority over counting.
		if (wr_en) begin
			case (addr)
				`CLK_CTRL_OFF: begin
					nxt_state.timer_prescale_select = pwdata[`TPS_MSB:`TPS_LSB];
					nxt_state.pre = 4'h0;
					nxt_state.pre2 = 4'h0;
				end
				`T0_CTRL_OFF, `T1_CTRL_OFF: begin
					nxt_state.t[addr[4]].run = pwdata[`TC_RUN_BIT];
					nxt_state.t[addr[4]].cnt_mode = pwdata[`TC_CMODE_BIT];
					nxt_state.t[addr[4]].reload_mode = pwdata[`TC_MODE_BIT];
					nxt_state.t[addr[4]].len = pwdata[`TC_LEN_MSB:`TC_LEN_LSB];
					nxt_state.t[addr[4]].pwm_en = pwdata[`TC_PWM_BIT];
				end
				`T0_CNT_OFF, `T1_CNT_OFF: nxt_state.t[addr[4]].cnt = pwdata[15:0];
				`T0_RLD_OFF, `T1_RLD_OFF: nxt_state.t[addr[4]].rld = pwdata[15:0];
				`T0_PWM_OFF: nxt_state.t[0].duty = pwdata[7:0];
				`T1_PWM_OFF: nxt_state.t[1].duty = pwdata[7:0];
				`T2_CTRL_OFF: begin
					nxt_state.t2_run = pwdata[`T2_RUN_BIT];
					nxt_state.t2_cmode = pwdata[`T2_CMODE_BIT];
					nxt_state.t2_cap = pwdata[`T2_CAP_BIT];
					nxt_state.t2_exen = pwdata[`T2_EXEN_BIT];
				end
				`T2_CNT_OFF: nxt_state.t2_cnt = pwdata[15:0];
				`T2_RLD_OFF: nxt_state.t2_rld = pwdata[15:0];
				`CC_EN_OFF: nxt_state.cc_en = pwdata[3:0];
				`WD_CTRL_OFF: begin
					nxt_state.wd_en = pwdata[`WD_EN_BIT];
					if (pwdata[`WD_CLR_BIT]) begin
						nxt_state.wd_cnt = 16'h0000;
					end
				end
				`WD_LIM_OFF: nxt_state.wd_lim = pwdata[15:0];
				default: begin
					for (int c = 0; c < CHANNELS; c++) begin
						if (addr == `CMP0_OFF + 8'(4 * c)) begin
							nxt_state.cmp[c] = pwdata[15:0];
						end
					end
				end
			endcase
		end

		// APB answer one cycle after setup.
		nxt_state.pready = setup_ph;
		if (setup_ph) begin
			nxt_state.prdata = (pwrite | ~hit) ? 32'h0000_0000 : rd;
			nxt_state.pslverr = ~hit;
		end else begin
			nxt_state.prdata = 32'h0000_0000;
			nxt_state.pslverr = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= '0;
			state_ff.timer_prescale_select <= `TPS_RST;
			state_ff.wd_lim <= `WD_LIM_RST;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign prdata = state_ff.prdata;
	assign pready = state_ff.pready;
	assign pslverr = state_ff.pslverr;
	assign tmr_out = state_ff.out;

endmodule

// ===== dv/pin_driver.sv
`timescale 1ns/1ps
module pin_driver
	import timebase_pkg::*;
(
	// Clock.
	input wire logic pclk,
	// Pins.
	output pin_in_type pins
);
	initial begin
		pins = '1;
	end
	task pulse(input int idx, input int n);
		repeat (n) begin
			@(posedge pclk);
			pins[idx] <= 1'b0;
			@(posedge pclk);
			pins[idx] <= 1'b1;
		end
	endtask
endmodule

// ===== dv/test_timer_timebase_prescaler.sv
`timescale 1ns/1ps
`include "timebase_consts.svh"
module test_timer_timebase_prescaler;
	import timebase_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, err;
	logic pready, pslverr;
	pin_in_type pins;
	tmr_out_type tmr_out;
	int bad_count = 0, comparisons = 0, i, k, dv;
	int cnt [7];
	int pexp [7] = '{'h80, 'h180, 'h80, 0, 2, 2, 2};
	logic [3:0] codes [4] = '{4'h0, 4'h1, 4'hB, 4'hD};
	logic [7:0] offs [4] = '{`T0_CNT_OFF, `T1_CNT_OFF, `T2_CNT_OFF, `WD_CNT_OFF};
	logic [15:0] a [4];
	logic [39:0] cfg [13] = '{{`T0_CTRL_OFF, 32'h81}, {`T0_PWM_OFF, 32'h40},
		{`T1_RLD_OFF, 32'hFF00}, {`T1_CNT_OFF, 32'hFF00}, {`T1_CTRL_OFF, 32'hF5},
		{`T1_PWM_OFF, 32'hC0}, {`T2_RLD_OFF, 32'hFF00}, {`T2_CNT_OFF, 32'hFF00},
		{`T2_CTRL_OFF, 32'h1}, {`CMP0_OFF, 32'hFF40}, {`CC_EN_OFF, 32'h1},
		{`WD_LIM_OFF, 32'hFF}, {`WD_CTRL_OFF, 32'h3}};
	always #2.5 pclk = ~pclk;
	timer_timebase_prescaler i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
		.tmr_out(tmr_out));
	pin_driver i_pins (.pclk(pclk), .pins(pins));
	task tally_and_finish;
		if (bad_count == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task xfer(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			bad_count++;
			tally_and_finish;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task wr(input logic [7:0] ad, input logic [31:0] wd);
		xfer(1'b1, ad, wd);
	endtask
	task rdr(input logic [7:0] ad);
		xfer(1'b0, ad, 32'h0);
	endtask
	initial begin
		repeat (100000) @(posedge pclk);
		bad_count++;
		tally_and_finish;
	end
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdr(`CLK_CTRL_OFF);
		check("prescale reset", rd, 32'h0);
		rdr(`WD_LIM_OFF);
		check("limit reset", rd, 32'hFFFF);
		rdr(8'h50);
		check("unmapped error", {err[0], rd[30:0]}, 32'h80000000);
		wr(`T0_CTRL_OFF, 32'h1);
		wr(`T1_CTRL_OFF, 32'h71);
		wr(`T2_CTRL_OFF, 32'h5);
		wr(`WD_CTRL_OFF, 32'h1);
		for (i = 0; i < 4; i++) begin
			wr(`CLK_CTRL_OFF, {28'h0, codes[i]});
			rdr(`CLK_CTRL_OFF);
			check("prescale field", rd, {28'h0, codes[i]});
			for (k = 0; k < 4; k++) begin
				rdr(offs[k]);
				a[k] = rd[15:0];
			end
			repeat (156) @(posedge pclk);
			for (k = 0; k < 4; k++) begin
				rdr(offs[k]);
				dv = (k == 2 && codes[i] == 4'hD) ? 12 : codes[i] + 1;
				if (k == 0)
					check("t0 length", rd[15:9], 32'h0);
				check("step", (rd[15:0] - a[k]) & (k == 0 ? 16'h1FF : 16'hFFFF), 168 / dv);
			end
		end
		wr(`CLK_CTRL_OFF, 32'h0);
		wr(`T0_CTRL_OFF, 32'h73);
		wr(`T2_CTRL_OFF, 32'h3);
		for (k = 0; k < 2; k++) begin
			rdr(k == 0 ? `T0_CNT_OFF : `T2_CNT_OFF);
			a[0] = rd[15:0];
			i_pins.pulse(k == 0 ? 3 : 1, 5);
			repeat (3) @(posedge pclk);
			rdr(k == 0 ? `T0_CNT_OFF : `T2_CNT_OFF);
			check("pin count", rd[15:0] - a[0], 32'h5);
		end
		for (k = 0; k < 13; k++)
			wr(cfg[k][39:32], cfg[k][31:0]);
		repeat (4) @(posedge pclk);
		cnt = '{default: 0};
		repeat (512) begin
			@(posedge pclk);
			cnt[0] += tmr_out.tmr_pwm[0];
			cnt[1] += tmr_out.tmr_pwm[1];
			cnt[2] += tmr_out.cc_pwm[0];
			cnt[3] += (tmr_out.cc_pwm[3:1] != 3'h0);
			cnt[4] += tmr_out.t1_baud;
			cnt[5] += tmr_out.t2_baud;
			cnt[6] += tmr_out.wd_timeout;
		end
		for (k = 0; k < 7; k++)
			check("output count", cnt[k], pexp[k]);
		tally_and_finish;
	end
endmodule
bind timer_timebase_prescaler timebase_checker i_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .tmr_out(tmr_out));

// ===== dv/timebase_checker.sv
`timescale 1ns/1ps
module timebase_checker
	import timebase_pkg::*;
(
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB.
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Timer outputs.
	input wire tmr_out_type tmr_out
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable && pready;
	endsequence
	property p_ready;
		s_setup |=> s_access;
	endproperty
	property p_one;
		pready |=> !pready;
	endproperty
	property p_unmapped;
		s_access and (paddr >= 8'h50) |-> pslverr && prdata == 32'h0;
	endproperty
	property p_mapped;
		s_access and (paddr < 8'h50) |-> !pslverr;
	endproperty
	property p_idle_data;
		!pready |-> prdata == 32'h0 && !pslverr;
	endproperty
	property p_reset_out;
		$rose(presetn) |-> tmr_out == '0;
	endproperty
	property p_t1_baud;
		tmr_out.t1_baud |=> !tmr_out.t1_baud [*2];
	endproperty
	property p_t2_baud;
		tmr_out.t2_baud |=> !tmr_out.t2_baud;
	endproperty
	property p_wd;
		tmr_out.wd_timeout |=> !tmr_out.wd_timeout;
	endproperty
	a_ready: assert property (p_ready) else $error("pready late");
	a_one: assert property (p_one) else $error("pready too long");
	a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
	a_mapped: assert property (p_mapped) else $error("mapped refused");
	a_idle_data: assert property (p_idle_data) else $error("data outside pready");
	a_reset_out: assert property (p_reset_out) else $error("outputs after reset");
	a_t1_baud: assert property (p_t1_baud) else $error("t1 baud width");
	a_t2_baud: assert property (p_t2_baud) else $error("t2 baud width");
	a_wd: assert property (p_wd) else $error("timeout width");
endmodule
